// [verilog/bsc_pkg.sv]
// Shared constants, opcodes, carriers and helpers of the branch/skip unit
package bsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PC_W  = 16;              // Program counter width in words
  localparam int REL_W = 7;               // Relative branch offset width
  localparam int CNT_W = 3;               // Cycle counter width

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions inside the core flag register
  localparam int FLAG_C = 0;              // Carry
  localparam int FLAG_Z = 1;              // Zero
  localparam int FLAG_N = 2;              // Negative
  localparam int FLAG_V = 3;              // Two's complement overflow
  localparam int FLAG_S = 4;              // Sign, N xor V
  localparam int FLAG_H = 5;              // Half carry
  localparam int FLAG_T = 6;              // Bit copy storage
  localparam int FLAG_I = 7;              // Global interrupt enable

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts per instruction class
  localparam logic [CNT_W-1:0] CYC_ONE        = 3'h1; // Sequential finish
  localparam logic [CNT_W-1:0] CYC_BR_TAKEN   = 3'h2; // Taken branch
  localparam logic [CNT_W-1:0] CYC_SKIP_SHORT = 3'h2; // Skip a one-word op
  localparam logic [CNT_W-1:0] CYC_SKIP_LONG  = 3'h3; // Skip a two-word op
  localparam logic [CNT_W-1:0] CYC_CALL       = 3'h3; // Indirect call
  localparam logic [CNT_W-1:0] CYC_RETURN     = 3'h4; // Both returns

  ////////////////////////////////////////////////////////////////////////////
  // Program counter steps
  localparam logic [PC_W-1:0] STEP_SEQ        = 16'h0001; // Next word
  localparam logic [PC_W-1:0] STEP_SKIP_SHORT = 16'h0002; // Over one word
  localparam logic [PC_W-1:0] STEP_SKIP_LONG  = 16'h0003; // Over two words

  // Reset values
  localparam logic [PC_W-1:0] PC_RST    = 16'h0000; // Held target at reset
  localparam logic [7:0]      FLAGS_RST = 8'h00;    // Flag output at reset

  ////////////////////////////////////////////////////////////////////////////
  // Operations handled by the unit
  typedef enum logic [4:0] {
    OP_NONE                     = 5'h00,
    OP_INDIRECT_CALL            = 5'h01,
    OP_SUBROUTINE_RETURN        = 5'h02,
    OP_INTERRUPT_RETURN         = 5'h03,
    OP_COMPARE_SKIP_EQUAL       = 5'h04,
    OP_REGISTER_COMPARE         = 5'h05,
    OP_COMPARE_WITH_CARRY       = 5'h06,
    OP_COMPARE_IMMEDIATE        = 5'h07,
    OP_SKIP_IF_REG_BIT_CLEAR    = 5'h08,
    OP_SKIP_IF_REG_BIT_SET      = 5'h09,
    OP_SKIP_IF_IO_BIT_CLEAR     = 5'h0a,
    OP_SKIP_IF_IO_BIT_SET       = 5'h0b,
    OP_BRANCH_IF_FLAG_SET       = 5'h0c,
    OP_BRANCH_IF_FLAG_CLEAR     = 5'h0d,
    OP_BRANCH_IF_EQUAL          = 5'h0e,
    OP_BRANCH_IF_NOT_EQUAL      = 5'h0f,
    OP_BRANCH_IF_CARRY_SET      = 5'h10,
    OP_BRANCH_IF_CARRY_CLEAR    = 5'h11,
    OP_BRANCH_IF_SAME_OR_HIGHER = 5'h12,
    OP_BRANCH_IF_LOWER          = 5'h13,
    OP_BRANCH_IF_MINUS          = 5'h14,
    OP_BRANCH_IF_PLUS           = 5'h15,
    OP_BRANCH_IF_SIGNED_GE      = 5'h16,
    OP_BRANCH_IF_SIGNED_LT      = 5'h17,
    OP_BRANCH_IF_HALF_CARRY_SET = 5'h18,
    OP_BRANCH_IF_HALF_CARRY_CLR = 5'h19,
    OP_BRANCH_IF_TBIT_SET       = 5'h1a,
    OP_BRANCH_IF_TBIT_CLEAR     = 5'h1b,
    OP_BRANCH_IF_OVERFLOW_SET   = 5'h1c,
    OP_BRANCH_IF_OVERFLOW_CLEAR = 5'h1d,
    OP_BRANCH_IF_IRQ_ENABLED    = 5'h1e
  } bsc_op_t;

  // Sequencer states, Gray along idle to busy
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,                       // Ready for an instruction
    ST_BUSY = 2'h1                        // Counting out extra cycles
  } bsc_state_t;

  // Decoded instruction from the fetch stage
  typedef struct packed {
    bsc_op_t               op;            // Operation
    logic [2:0]            sel;           // Bit or flag index
    logic signed [REL_W-1:0] rel;         // Relative branch offset k
  } bsc_inst_t;

  // Result handed back to the core
  typedef struct packed {
    logic            done;                // Instruction complete pulse
    logic            pcLoad;              // Load pc from pc field
    logic [PC_W-1:0] pc;                  // Next program counter
    logic            flagsWe;             // Write flags field
    logic [7:0]      flags;               // New flag register value
    logic            push;                // Push return address pulse
    logic [PC_W-1:0] pushData;            // Return address to push
    logic            pop;                 // Pop return address pulse
  } bsc_result_t;

  ////////////////////////////////////////////////////////////////////////////
  // Add a step to a program counter, wrapping in PC_W bits
  function automatic logic [PC_W-1:0] pcAdd(input logic [PC_W-1:0] pc,
                                            input logic [PC_W-1:0] step);
    pcAdd = PC_W'(pc + step);
  endfunction : pcAdd

  // Condition of every flag-based branch
  function automatic logic branchCond(input bsc_op_t    op,
                                      input logic [7:0] f,
                                      input logic [2:0] sel);
    case (op)
      OP_BRANCH_IF_FLAG_SET:       branchCond = f[sel];
      OP_BRANCH_IF_FLAG_CLEAR:     branchCond = ~f[sel];
      OP_BRANCH_IF_EQUAL:          branchCond = f[FLAG_Z];
      OP_BRANCH_IF_NOT_EQUAL:      branchCond = ~f[FLAG_Z];
      OP_BRANCH_IF_CARRY_SET,
      OP_BRANCH_IF_LOWER:          branchCond = f[FLAG_C];
      OP_BRANCH_IF_CARRY_CLEAR,
      OP_BRANCH_IF_SAME_OR_HIGHER: branchCond = ~f[FLAG_C];
      OP_BRANCH_IF_MINUS:          branchCond = f[FLAG_N];
      OP_BRANCH_IF_PLUS:           branchCond = ~f[FLAG_N];
      OP_BRANCH_IF_SIGNED_GE:      branchCond = ~(f[FLAG_N] ^ f[FLAG_V]);
      OP_BRANCH_IF_SIGNED_LT:      branchCond = f[FLAG_N] ^ f[FLAG_V];
      OP_BRANCH_IF_HALF_CARRY_SET: branchCond = f[FLAG_H];
      OP_BRANCH_IF_HALF_CARRY_CLR: branchCond = ~f[FLAG_H];
      OP_BRANCH_IF_TBIT_SET:       branchCond = f[FLAG_T];
      OP_BRANCH_IF_TBIT_CLEAR:     branchCond = ~f[FLAG_T];
      OP_BRANCH_IF_OVERFLOW_SET:   branchCond = f[FLAG_V];
      OP_BRANCH_IF_OVERFLOW_CLEAR: branchCond = ~f[FLAG_V];
      OP_BRANCH_IF_IRQ_ENABLED:    branchCond = f[FLAG_I];
      default:                     branchCond = 1'b0;
    endcase
  endfunction : branchCond

endpackage : bsc_pkg

// [verilog/bsc_cmp_flags.sv]
// Flag generator for the three compare operations
module bsc_cmp_flags
  import bsc_pkg::*;
(
  input  wire logic [7:0] opA,            // Minuend, register d
  input  wire logic [7:0] opB,            // Subtrahend, register r or K
  input  wire logic       useCarry,       // Also subtract carry in
  input  wire logic [7:0] flagsIn,        // Current flag register
  output logic      [7:0] flagsOut        // Flag register after compare
);

  logic [7:0] diff;                       // Discarded difference
  logic       cIn;                        // Carry taken into subtraction

  ////////////////////////////////////////////////////////////////////////////
  // Subtract without storing, then derive the five arithmetic flags
  always_comb begin
    cIn  = useCarry & flagsIn[FLAG_C];
    diff = 8'(opA - opB - {7'h00, cIn});
    flagsOut = flagsIn;
    // Borrow out of bit 7
    flagsOut[FLAG_C] = (~opA[7] & opB[7]) | (opB[7] & diff[7]) |
                       (diff[7] & ~opA[7]);
    // Borrow out of bit 3
    flagsOut[FLAG_H] = (~opA[3] & opB[3]) | (opB[3] & diff[3]) |
                       (diff[3] & ~opA[3]);
    flagsOut[FLAG_N] = diff[7];
    flagsOut[FLAG_V] = (opA[7] & ~opB[7] & ~diff[7]) |
                       (~opA[7] & opB[7] & diff[7]);
    // Carry variant keeps zero only across a chain of zero bytes
    if (useCarry) begin
      flagsOut[FLAG_Z] = (diff == 8'h00) & flagsIn[FLAG_Z];
    end else begin
      flagsOut[FLAG_Z] = (diff == 8'h00);
    end
  end

endmodule : bsc_cmp_flags

// [verilog/bsc_branch_skip_compare_unit.sv]
// Control-flow unit: calls, returns, compares, skips and flag branches
//
// Notes on behaviour
// - Indirect call jumps to Z, 3 cycles
// - Equal registers skip next, 1/2/3 cycles
// - Compares subtract unstored, set Z N V C H
// - Register bit clear skips next instruction
// - Register bit set skips, flags untouched
// - I/O bit clear skips next instruction
// - I/O bit set skips, flags untouched
// - Selected flag set branches pc+k+1
// - Selected flag clear branches pc+k+1
// - Zero set branches, 1 or 2 cycles
// - Zero clear branches, 1 or 2 cycles
// - Carry set or lower branches
// - Carry clear or same/higher branches
// - Negative set or clear branches
// - N xor V zero branches
// - N xor V one branches
// - Half carry set or clear branches
// - T flag set or clear branches
// - Overflow set or clear branches
// - Interrupt enable set branches, flags kept
//
// Offers made while busy are dropped silently.
// Z is taken at the offer, the stack word at the end.
// Every op loads pc, a plain step included.
// Compare flags are formed every cycle, written by compares.
// Interrupt return writes only the interrupt enable, on the last cycle.
// Skip length comes from the size of the next op.
// A low ce stretches every count by the frozen cycles.

module bsc_branch_skip_compare_unit
  import bsc_pkg::*;
(
  input  wire logic            clk,        // Core clock, 125 MHz
  input  wire logic            sys_rst,    // Synchronous reset, high
  input  wire logic            ce,         // Clock enable, freezes state
  input  wire logic            instValid,  // Instruction offered
  input  wire bsc_inst_t       inst,       // Decoded instruction
  input  wire logic [7:0]      opA,        // Register d, or tested reg
  input  wire logic [7:0]      opB,        // Register r or immediate K
  input  wire logic [7:0]      ioByte,     // Addressed I/O register
  input  wire logic [7:0]      flagsIn,    // Core flag register
  input  wire logic [PC_W-1:0] zPtr,       // Z pointer pair
  input  wire logic [PC_W-1:0] pcIn,       // Address of this instruction
  input  wire logic            nextIsLong, // Following op is two words
  input  wire logic [PC_W-1:0] stackPc,    // Popped return address
  output logic                 busy,       // Unit busy, refuses offers
  output bsc_result_t          result      // Registered result
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  // Position and cycles still to run
  bsc_state_t        state_ff;             // Sequencer state
  bsc_state_t        nxt_state;            // Next sequencer state
  logic [CNT_W-1:0]  count_ff;             // Cycles left incl. last
  logic [CNT_W-1:0]  nxt_count;            // Next cycle count

  // Target and its source, kept over the busy cycles
  logic [PC_W-1:0]   target_ff;            // Held pc target
  logic [PC_W-1:0]   nxt_target;           // Next held target
  logic              fromStack_ff;         // Target comes from stack
  logic              nxt_fromStack;        // Next stack select
  logic              setIrq_ff;            // Return re-enables irqs
  logic              nxt_setIrq;           // Next irq re-enable

  // Output flops
  logic              busy_ff;              // Busy output flop
  logic              nxt_busy;             // Next busy
  bsc_result_t       result_ff;            // Result output flop
  bsc_result_t       nxt_result;           // Next result

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  logic              accept;               // Instruction taken now
  logic              isCompare;            // One of the three compares
  logic              useCarry;             // Carry variant of compare
  logic [7:0]        cmpFlags;             // Flags after compare

  // Conditions of the offered op
  logic              skipTaken;            // Skip condition holds
  logic              brTaken;              // Branch condition holds

  // Offsets and step sizes
  logic [PC_W-1:0]   relExt;               // Sign-extended offset
  logic [PC_W-1:0]   skipStep;             // Words to skip over
  logic [CNT_W-1:0]  skipCycles;           // Cycles of a taken skip

  // Resolved cost and destination
  logic [CNT_W-1:0]  cycles;               // Total cycles of this op
  logic [PC_W-1:0]   target;               // Resolved pc target

  ////////////////////////////////////////////////////////////////////////////
  // Compare flag generator
  // Pure logic, no state of its own
  bsc_cmp_flags u_cmp (
    .opA      (opA),
    .opB      (opB),
    .useCarry (useCarry),
    .flagsIn  (flagsIn),
    .flagsOut (cmpFlags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operand decode and condition evaluation
  always_comb begin
    // Busy offers are ignored, no retry
    accept    = instValid & (state_ff == ST_IDLE);
    isCompare = (inst.op == OP_REGISTER_COMPARE) |
                (inst.op == OP_COMPARE_WITH_CARRY) |
                (inst.op == OP_COMPARE_IMMEDIATE);
    useCarry  = (inst.op == OP_COMPARE_WITH_CARRY);
    relExt    = PC_W'(signed'(inst.rel));
    // Skip length follows the size of the skipped instruction
    skipStep   = nextIsLong ? STEP_SKIP_LONG : STEP_SKIP_SHORT;
    skipCycles = nextIsLong ? CYC_SKIP_LONG : CYC_SKIP_SHORT;

    // Condition of each skip op
    case (inst.op)
      OP_COMPARE_SKIP_EQUAL:    skipTaken = (opA == opB);
      OP_SKIP_IF_REG_BIT_CLEAR: skipTaken = ~opA[inst.sel];
      OP_SKIP_IF_REG_BIT_SET:   skipTaken = opA[inst.sel];
      OP_SKIP_IF_IO_BIT_CLEAR:  skipTaken = ~ioByte[inst.sel];
      OP_SKIP_IF_IO_BIT_SET:    skipTaken = ioByte[inst.sel];
      default:                  skipTaken = 1'b0;
    endcase

    brTaken = branchCond(inst.op, flagsIn, inst.sel);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle count and target of the offered instruction
  always_comb begin
    // One cycle to the next word unless changed below
    cycles = CYC_ONE;
    target = pcAdd(pcIn, STEP_SEQ);

    case (inst.op)
      OP_INDIRECT_CALL: begin
        cycles = CYC_CALL;
        target = zPtr;
      end

      OP_SUBROUTINE_RETURN,
      OP_INTERRUPT_RETURN: begin
        cycles = CYC_RETURN;
        target = stackPc;
      end

      OP_COMPARE_SKIP_EQUAL,
      OP_SKIP_IF_REG_BIT_CLEAR,
      OP_SKIP_IF_REG_BIT_SET,
      OP_SKIP_IF_IO_BIT_CLEAR,
      OP_SKIP_IF_IO_BIT_SET: begin
        if (skipTaken) begin
          cycles = skipCycles;
          target = pcAdd(pcIn, skipStep);
        end
      end

      OP_REGISTER_COMPARE,
      OP_COMPARE_WITH_CARRY,
      OP_COMPARE_IMMEDIATE: begin
        cycles = CYC_ONE;
      end

      // Flag branches; other ops fall through as a step
      default: begin
        if (brTaken) begin
          cycles = CYC_BR_TAKEN;
          target = pcAdd(pcAdd(pcIn, relExt), STEP_SEQ);
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state and result
  always_comb begin
    nxt_state     = state_ff;
    nxt_count     = count_ff;
    nxt_target    = target_ff;
    nxt_fromStack = fromStack_ff;
    nxt_setIrq    = setIrq_ff;
    nxt_busy      = busy_ff;

    // Pulses drop each cycle, levels hold
    nxt_result          = result_ff;
    nxt_result.done     = 1'b0;
    nxt_result.pcLoad   = 1'b0;
    nxt_result.flagsWe  = 1'b0;
    nxt_result.push     = 1'b0;
    nxt_result.pop      = 1'b0;

    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_target    = target;
          nxt_fromStack = (inst.op == OP_SUBROUTINE_RETURN) |
                          (inst.op == OP_INTERRUPT_RETURN);
          nxt_setIrq    = (inst.op == OP_INTERRUPT_RETURN);

          if (inst.op == OP_INDIRECT_CALL) begin
            nxt_result.push     = 1'b1;
            nxt_result.pushData = pcAdd(pcIn, STEP_SEQ);
          end

          if (nxt_fromStack) begin
            nxt_result.pop = 1'b1;
          end

          if (cycles == CYC_ONE) begin
            // Single-cycle finish on the next edge
            nxt_result.done    = 1'b1;
            nxt_result.pcLoad  = 1'b1;
            nxt_result.pc      = target;
            nxt_result.flagsWe = isCompare;
            nxt_result.flags   = isCompare ? cmpFlags : flagsIn;
          end else begin
            // Multi-cycle, count out the remainder
            nxt_state = ST_BUSY;
            nxt_busy  = 1'b1;
            nxt_count = CNT_W'(cycles - CYC_ONE);
          end
        end
      end

      // Count down, finish when one is left
      ST_BUSY: begin
        nxt_count = CNT_W'(count_ff - CYC_ONE);
        if (count_ff == CYC_ONE) begin
          nxt_state         = ST_IDLE;
          nxt_busy          = 1'b0;
          nxt_result.done   = 1'b1;
          nxt_result.pcLoad = 1'b1;
          nxt_result.pc     = fromStack_ff ? stackPc : target_ff;
          nxt_result.flagsWe = setIrq_ff;
          nxt_result.flags   = flagsIn | (8'h01 << FLAG_I);
        end
      end

      // Unused encodings fall back to idle
      default: begin
        nxt_state = ST_IDLE;
        nxt_busy  = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers, frozen while ce is low
  always_ff @(posedge clk) begin
    // Reset wins over a low ce
    if (sys_rst) begin
      state_ff     <= ST_IDLE;
      count_ff     <= '0;
      target_ff    <= PC_RST;
      fromStack_ff <= 1'b0;
      setIrq_ff    <= 1'b0;
      busy_ff      <= 1'b0;
      result_ff    <= '{done: 1'b0, pcLoad: 1'b0, pc: PC_RST,
                        flagsWe: 1'b0, flags: FLAGS_RST, push: 1'b0,
                        pushData: PC_RST, pop: 1'b0};
    end else if (ce) begin
      // Advance only while enabled
      state_ff     <= nxt_state;
      count_ff     <= nxt_count;
      target_ff    <= nxt_target;
      fromStack_ff <= nxt_fromStack;
      setIrq_ff    <= nxt_setIrq;
      busy_ff      <= nxt_busy;
      result_ff    <= nxt_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  // Nothing between flop and port
  assign busy   = busy_ff;
  assign result = result_ff;

endmodule : bsc_branch_skip_compare_unit

// [bench/bsc_unit_properties.sv]
// Port-level assertions of the branch/skip/compare unit
module bsc_unit_properties
  import bsc_pkg::*;
(
  input wire logic            clk,        // Core clock
  input wire logic            sys_rst,    // Sync reset
  input wire logic            ce,         // Clock enable
  input wire logic            instValid,  // Offer strobe
  input wire bsc_inst_t       inst,       // Offered op
  input wire logic [7:0]      opA,        // Register d
  input wire logic [7:0]      opB,        // Register r or K
  input wire logic [7:0]      ioByte,     // I/O byte
  input wire logic [7:0]      flagsIn,    // Flags in
  input wire logic [PC_W-1:0] zPtr,       // Z pointer
  input wire logic [PC_W-1:0] pcIn,       // Offered address
  input wire logic            nextIsLong, // Long successor
  input wire logic [PC_W-1:0] stackPc,    // Popped address
  input wire logic            busy,       // Unit busy
  input wire bsc_result_t     result      // Result
);
  timeunit 1ns;
  timeprecision 1ps;

  // Sign-extended branch offset
  logic [PC_W-1:0] relX;
  assign relX = {{(PC_W-REL_W){inst.rel[REL_W-1]}}, inst.rel};

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Offer taken by an idle unit
  sequence take(bsc_op_t o);
    ce && instValid && !busy && inst.op == o;
  endsequence
  // One-cycle finish at the next word
  sequence seqEnd;
    result.done && !busy && result.pc == PC_W'($past(pcIn) + 1);
  endsequence

  call_jump_a: assert property (
    take(OP_INDIRECT_CALL) |=> (busy && result.push
    && result.pushData == PC_W'($past(pcIn) + 1)) ##1 busy
    ##1 (result.done && result.pc == $past(zPtr, 3)))
    else $error("indirect call sequence wrong");
  ret_pop_a: assert property (
    take(OP_SUBROUTINE_RETURN) |=> (busy && result.pop) ##1 busy[*2]
    ##1 (result.done && !result.flagsWe && result.pc == $past(stackPc)))
    else $error("subroutine return sequence wrong");
  interrupt_return_flags_a: assert property (
    take(OP_INTERRUPT_RETURN) ##4 1 |-> result.done && result.flagsWe
    && result.flags == ($past(flagsIn) | 8'h80))
    else $error("interrupt return flags wrong");
  skip_equal_a: assert property (
    take(OP_COMPARE_SKIP_EQUAL) ##0 (opA == opB && !nextIsLong) |=> busy
    ##1 (result.done && !result.flagsWe
    && result.pc == PC_W'($past(pcIn, 2) + 2)))
    else $error("equal skip wrong");
  cmp_zero_a: assert property (
    take(OP_REGISTER_COMPARE) ##0 (opA == opB) |=> seqEnd
    ##0 (result.flagsWe && result.flags[FLAG_Z] && !result.flags[FLAG_C]))
    else $error("compare flags wrong");
  bit_clear_a: assert property (
    take(OP_SKIP_IF_REG_BIT_CLEAR) ##0 opA[inst.sel] |=> seqEnd)
    else $error("bit clear skip wrong");
  // set I/O bit skips two words
  io_long_a: assert property (
    take(OP_SKIP_IF_IO_BIT_SET) ##0 (ioByte[inst.sel] && nextIsLong)
    |=> busy[*2] ##1 (result.done && !result.flagsWe
    && result.pc == PC_W'($past(pcIn, 3) + 3)))
    else $error("io bit set skip wrong");
  eq_taken_a: assert property (
    take(OP_BRANCH_IF_EQUAL) ##0 flagsIn[FLAG_Z] |=> busy ##1 (result.done
    && result.pc == PC_W'($past(pcIn, 2) + $past(relX, 2) + 1)))
    else $error("equal branch wrong");
endmodule : bsc_unit_properties

bind bsc_branch_skip_compare_unit bsc_unit_properties u_props (
  .clk, .sys_rst, .ce, .instValid, .inst, .opA, .opB, .ioByte, .flagsIn,
  .zPtr, .pcIn, .nextIsLong, .stackPc, .busy, .result);

// [bench/bsc_unit_tb.sv]
// Self-checking bench of the branch/skip/compare unit
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin errTotal++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb
  import bsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic            clk = 1'b0;          // Core clock
  logic            sys_rst = 1'b1;      // Reset
  logic            ce = 1'b1;           // Clock enable
  logic            instValid = 1'b0;    // Offer strobe
  logic            nextIsLong = 1'b0;   // Long successor
  bsc_inst_t       inst = '0;           // Offered op
  logic [7:0]      opA = 8'h00;         // Register d
  logic [7:0]      opB = 8'h00;         // Register r or K
  logic [7:0]      ioByte = 8'h00;      // I/O byte
  logic [7:0]      flagsIn = 8'h00;     // Flags in
  logic [PC_W-1:0] zPtr = 16'h0000;     // Z pointer
  logic [PC_W-1:0] pcIn = 16'h0000;     // Offered address
  logic [PC_W-1:0] stackPc = 16'h0000;  // Popped address
  logic            busy;                // Unit busy
  bsc_result_t     result;              // Unit result
  int              errTotal = 0;        // Mismatches
  int              nChecks = 0;         // Comparisons

  always #4 clk = ~clk;

  bsc_branch_skip_compare_unit DUT (.clk, .sys_rst, .ce, .instValid, .inst,
    .opA, .opB, .ioByte, .flagsIn, .zPtr, .pcIn, .nextIsLong, .stackPc,
    .busy, .result);

  ////////////////////////////////////////////////////////////////////////////
  // Offer one op at this edge, count cycles up to done
  task automatic go(input bsc_op_t o, input logic [2:0] s,
                    input logic [6:0] k, input logic [15:0] pc,
                    output logic [3:0] n);
    pcIn      <= pc;
    inst      <= '{op: o, sel: s, rel: k};
    instValid <= 1'b1;
    @(posedge clk);
    instValid <= 1'b0;
    zPtr      <= ~zPtr;  // Z must be taken at the offer
    n = 4'h1;
    #1;
    while (result.done !== 1'b1 && n < 4'h8) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : go

  // Indirect call
  task automatic callScen();
    logic [3:0] n;
    @(posedge clk);
    zPtr <= 16'h0abc;
    go(OP_INDIRECT_CALL, 3'h0, 7'h00, 16'h1234, n);
    `CHK(n, 4'h3)
    `CHK({result.flagsWe, result.pc}, {1'b0, 16'h0abc})
    `CHK(result.pushData, 16'h1235)
  endtask : callScen

  // Both returns
  task automatic retScen();
    logic [3:0] n;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      stackPc <= 16'h0456;
      flagsIn <= 8'h2b;
      go(i ? OP_INTERRUPT_RETURN : OP_SUBROUTINE_RETURN, 3'h0, 7'h00,
         16'h0300, n);
      `CHK(n, 4'h4)
      `CHK({result.flagsWe, result.pc}, {1'(i), 16'h0456})
    end
    `CHK(result.flags, 8'hab)
  endtask : retScen

  // One compare with its expected flags
  task automatic cmpOne(input bsc_op_t o, input logic [7:0] a, b, f, e);
    logic [3:0] n;
    @(posedge clk);
    opA     <= a;
    opB     <= b;
    flagsIn <= f;
    go(o, 3'h0, 7'h00, 16'h0100, n);
    `CHK(n, 4'h1)
    `CHK(result.flags, e)
    `CHK({result.flagsWe, result.pc}, {1'b1, 16'h0101})
  endtask : cmpOne

  // One skip with its expected cycle count
  task automatic skipOne(input bsc_op_t o, input logic [2:0] s,
                         input logic [7:0] a, io, input logic lng,
                         input logic [3:0] e);
    logic [3:0] n;
    @(posedge clk);
    opA        <= a;
    opB        <= 8'h5a;
    ioByte     <= io;
    nextIsLong <= lng;
    go(o, s, 7'h00, 16'h0200, n);
    `CHK(n, e)
    `CHK({result.flagsWe, result.pc}, {1'b0, 16'h0200 + e})
  endtask : skipOne

  // Every flag branch against three flag patterns
  task automatic branchScen();
    int          bitOf [19] = '{0,0,1,1,0,0,0,0,2,2,8,8,5,5,6,6,3,3,7};
    bit          pol [19] = '{1,0,1,0,1,0,0,1,1,0,0,1,1,0,1,0,1,0,1};
    logic [7:0]  fv [3] = '{8'h00, 8'hff, 8'h55};
    logic [8:0]  g;
    logic [2:0]  s;
    logic        t;
    logic [3:0]  n;
    for (int i = 0; i < 19; i++) begin
      for (int j = 0; j < 3; j++) begin
        s = 3'(i + j);
        g = {fv[j][FLAG_N] ^ fv[j][FLAG_V], fv[j]};
        t = (g[i < 2 ? int'(s) : bitOf[i]] == pol[i]);
        @(posedge clk);
        flagsIn <= fv[j];
        go(bsc_op_t'(5'(12 + i)), s, 7'h7d, 16'h0001, n);
        `CHK(n, t ? 4'h2 : 4'h1)
        `CHK(result.pc, t ? 16'hffff : 16'h0002)
      end
    end
  endtask : branchScen

  // Clock enable low freezes a taken branch
  task automatic ceScen();
    @(posedge clk);
    flagsIn   <= 8'h00;
    pcIn      <= 16'h0040;
    inst      <= '{op: OP_BRANCH_IF_NOT_EQUAL, sel: 3'h0, rel: 7'h02};
    instValid <= 1'b1;
    @(posedge clk);
    instValid <= 1'b0;
    ce        <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    #1;
    `CHK({busy, result.done}, 2'b10)
    @(posedge clk);
    #1;
    `CHK({busy, result.done}, 2'b01)
    `CHK({result.pcLoad, result.pc}, {1'b1, 16'h0043})
  endtask : ceScen

  // Verdict and end of run
  task automatic tallyAndFinish();
    $display("checks=%0d errors=%0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tallyAndFinish

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    callScen();
    retScen();
    cmpOne(OP_REGISTER_COMPARE, 8'h3c, 8'h3c, 8'hc0, 8'hc2);
    cmpOne(OP_COMPARE_IMMEDIATE, 8'h80, 8'h01, 8'hc0, 8'he8);
    cmpOne(OP_COMPARE_WITH_CARRY, 8'h05, 8'h04, 8'hc3, 8'hc2);
    skipOne(OP_COMPARE_SKIP_EQUAL, 3'h0, 8'h5a, 8'h00, 1'b0, 4'h2);
    skipOne(OP_COMPARE_SKIP_EQUAL, 3'h0, 8'h5b, 8'h00, 1'b1, 4'h1);
    skipOne(OP_SKIP_IF_REG_BIT_CLEAR, 3'h0, 8'hfe, 8'h00, 1'b1, 4'h3);
    skipOne(OP_SKIP_IF_REG_BIT_CLEAR, 3'h7, 8'h80, 8'h00, 1'b0, 4'h1);
    skipOne(OP_SKIP_IF_REG_BIT_SET, 3'h3, 8'h08, 8'h00, 1'b0, 4'h2);
    skipOne(OP_SKIP_IF_IO_BIT_CLEAR, 3'h2, 8'hff, 8'hfb, 1'b0, 4'h2);
    skipOne(OP_SKIP_IF_IO_BIT_SET, 3'h7, 8'h00, 8'h80, 1'b1, 4'h3);
    skipOne(OP_SKIP_IF_IO_BIT_SET, 3'h7, 8'hff, 8'h7f, 1'b0, 4'h1);
    branchScen();
    ceScen();
    tallyAndFinish();
  end

  // Watchdog, well past the expected run length
  initial begin
    #20000;
    errTotal++;
    tallyAndFinish();
  end
endmodule : tb
